// *** inc/vpo_consts.svh ***
// constants of the video pixel output port: register map, field bits, codes, limits
// assumes inclusion by bare name from the limiter and top design files
`ifndef VPO_CONSTS_SVH
`define VPO_CONSTS_SVH

// output format control register
`define VPO_OFC_ADDR     8'h12
`define VPO_OFC_RESET    8'h00
`define VPO_OFC_WMASK    8'h0f
`define VPO_BIT_W8       0
`define VPO_BIT_MODE2    1
`define VPO_BIT_RANGE    2
`define VPO_BIT_CODE     3
`define VPO_CFG_W        4
`define VPO_CFG_RESET    4'h0

// control codes carried in the luma byte
`define VPO_CC_INVALID   8'h00
`define VPO_CC_LAST_ACT  8'h01
`define VPO_CC_FIRST_ACT 8'h02
`define VPO_CC_LS_ACT    8'h03
`define VPO_CC_LS_BLANK  8'h04
`define VPO_CC_FS_EVEN   8'h05
`define VPO_CC_FS_ODD    8'h06

// chroma bytes that mark a control code
`define VPO_CB_MARK      8'hff
`define VPO_CR_MARK      8'hfe

// value levels
`define VPO_C_ZERO       8'h80
`define VPO_Y_BLACK      8'h10
`define VPO_Y_BLACK_FULL 8'h00
`define VPO_C_LO         8'h02
`define VPO_C_HI         8'hfd
`define VPO_Y_LO_STUDIO  8'h10
`define VPO_Y_HI_STUDIO  8'heb
`define VPO_Y_LO_CODED   8'h10
`define VPO_Y_HI_CODED   8'hfd
`define VPO_Y_LO_FULL    8'h00
`define VPO_Y_HI_FULL    8'hff

`endif

// *** inc/vpo_pkg.sv ***
// types of the video pixel output port
// assumes vpo_consts.svh on the include path
package vpo_pkg;
   // byte slot within one pixel period on the full-rate clock
   typedef enum logic {
      VPO_PH_CHROMA,
      VPO_PH_LUMA
   } vpo_phase_t;
endpackage

// *** core/vpo_sync3.sv ***
// three-stage level synchroniser with agreement filter
// assumes d_in is static for several destination clocks around each change
`timescale 1ns/1ns
module vpo_sync3 #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   wire  logic   agree = (s2_reg == s3_reg);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
         q_out  <= RST_VAL;
      end else begin
         s1_reg <= d_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (agree) begin
            q_out <= s3_reg;
         end
      end
   end
endmodule

// *** core/vpo_pix_limit.sv ***
// value range limiter for one luma and one chroma sample
// assumes range and code bits come from the output format control
`timescale 1ns/1ns
`include "vpo_consts.svh"
module vpo_pix_limit (
   input  wire logic [7:0] y_in,
   input  wire logic [7:0] c_in,
   input  wire logic       range_in,
   input  wire logic       code_in,
   output logic      [7:0] y_out,
   output logic      [7:0] c_out
);
   wire logic       coded = range_in & code_in;
   wire logic [7:0] y_lo  = coded ? `VPO_Y_LO_CODED :
                            range_in ? `VPO_Y_LO_FULL : `VPO_Y_LO_STUDIO;
   wire logic [7:0] y_hi  = coded ? `VPO_Y_HI_CODED :
                            range_in ? `VPO_Y_HI_FULL : `VPO_Y_HI_STUDIO;

   // luma window by range setting
   assign y_out = (y_in < y_lo) ? y_lo : (y_in > y_hi) ? y_hi : y_in;
   // chroma never reaches the marker values
   assign c_out = (c_in < `VPO_C_LO) ? `VPO_C_LO :
                  (c_in > `VPO_C_HI) ? `VPO_C_HI : c_in;
endmodule

// *** core/vpo_top.sv ***
// video pixel output port: format register, pixel formatter, timing code insertion
// assumes source pixel inputs are on the full-rate pixel clock and register port on ref clock
`timescale 1ns/1ns
`include "vpo_consts.svh"

//Behaviour
//- pixel port carries 4:2:2 as 8 or 16 bits
//- 16-bit per half-rate clock, 8-bit per full-rate
//- format register at 0x12 selects mode, width
//- reset gives Mode 1, 16-bit width
//- 8-bit uses upper lanes, chroma before luma
//- 16-bit: luma upper lanes, chroma lower lanes
//- Mode 1 sends blanking and active pixels
//- Mode 2 carries line, field timing as codes
//- coded range: chroma 2..253, luma 16..253
//- chroma 255/254 marks code, Cb/Cr flag
//- codes 0,1,2: invalid, after last, before first
//- line sync code 3 active, 4 blanking
//- field sync code 5 even, 6 odd
//- first line pixel Cb; line code may slip
//- field code may sit on Cb or Cr
//- zero colour is chroma 128 always
//- black is 16 unlimited, 0 limited
//- unlimited luma 16..235, never 0 or 255
module vpo_top (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   input  wire logic        reg_wr_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   output logic      [7:0]  reg_rdata_out,
   input  wire logic        full_rate_pixel_clock_in,
   input  wire logic [7:0]  src_y_in,
   input  wire logic [7:0]  src_c_in,
   input  wire logic        src_active_in,
   input  wire logic        src_vblank_in,
   input  wire logic        src_hsync_in,
   input  wire logic        src_vsync_in,
   input  wire logic        src_odd_field_in,
   output logic             src_take_out,
   output logic             half_rate_pixel_clock_out,
   output logic      [15:0] pixel_data_lanes_out,
   output logic             line_sync_marker_n_out,
   output logic             field_sync_marker_n_out
);
   // ---------------- register side, ref clock ----------------
   logic [7:0] output_format_control_reg;
   logic [7:0] output_format_control_next;
   logic [7:0] rdata_next;
   wire  logic ofc_hit = (reg_addr_in == `VPO_OFC_ADDR);

   assign output_format_control_next = (reg_wr_in && ofc_hit) ?
                                       (reg_wdata_in & `VPO_OFC_WMASK) :
                                       output_format_control_reg;
   assign rdata_next = ofc_hit ? output_format_control_reg : 8'h00;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         output_format_control_reg <= `VPO_OFC_RESET;
         reg_rdata_out             <= 8'h00;
      end else if (ce_in) begin
         output_format_control_reg <= output_format_control_next;
         reg_rdata_out             <= rdata_next;
      end
   end

   // ---------------- crossings into the pixel domain ----------------
   logic [1:0]            ctl_s;
   logic [`VPO_CFG_W-1:0] cfg_s;
   wire  logic            rst_p = ctl_s[1];
   wire  logic            ce_p  = ctl_s[0];

   vpo_sync3 #(.W(2), .RST_VAL(2'h0)) u_ctl_sync (
      .clk_in (full_rate_pixel_clock_in),
      .rst_in (1'b0),
      .d_in   ({rst_in, ce_in}),
      .q_out  (ctl_s)
   );

   vpo_sync3 #(.W(`VPO_CFG_W), .RST_VAL(`VPO_CFG_RESET)) u_cfg_sync (
      .clk_in (full_rate_pixel_clock_in),
      .rst_in (rst_p),
      .d_in   (output_format_control_reg[`VPO_CFG_W-1:0]),
      .q_out  (cfg_s)
   );

   // ---------------- pixel side, full-rate clock ----------------
   vpo_pkg::vpo_phase_t   ph_reg;
   vpo_pkg::vpo_phase_t   ph_next;
   logic [`VPO_CFG_W-1:0] cfg_reg;
   logic [7:0]            st_y_reg;
   logic [7:0]            st_c_reg;
   logic                  st_act_reg;
   logic                  st_cb_reg;
   logic                  prev_act_reg;
   logic                  pend_h_reg;
   logic                  pend_hvb_reg;
   logic                  pend_v_reg;
   logic                  pend_odd_reg;
   logic [7:0]            y_hold_reg;
   logic [15:0]           lanes_next;
   logic [7:0]            lim_y;
   logic [7:0]            lim_c;
   logic [7:0]            ctl_y;

   always_comb begin
      unique case (ph_reg)
         vpo_pkg::VPO_PH_CHROMA: ph_next = vpo_pkg::VPO_PH_LUMA;
         vpo_pkg::VPO_PH_LUMA:   ph_next = vpo_pkg::VPO_PH_CHROMA;
      endcase
   end

   // pixel boundary: new pixel taken and launched
   wire logic            stb     = (ph_reg == vpo_pkg::VPO_PH_CHROMA);
   wire logic [`VPO_CFG_W-1:0] cfg_use = stb ? cfg_s : cfg_reg;
   wire logic            w8      = cfg_use[`VPO_BIT_W8];
   wire logic            mode2   = cfg_use[`VPO_BIT_MODE2];
   wire logic            range   = cfg_use[`VPO_BIT_RANGE];
   wire logic            code_en = cfg_use[`VPO_BIT_CODE];

   assign src_take_out              = stb & ce_p & ~rst_p;
   assign half_rate_pixel_clock_out = (ph_reg == vpo_pkg::VPO_PH_LUMA);

   vpo_pix_limit u_limit (
      .y_in     (st_y_reg),
      .c_in     (st_c_reg),
      .range_in (range),
      .code_in  (code_en),
      .y_out    (lim_y),
      .c_out    (lim_c)
   );

   // position codes and pending markers
   wire logic first_act = ~st_act_reg & src_active_in;
   wire logic last_act  = ~st_act_reg & prev_act_reg & ~first_act;
   wire logic is_code   = mode2 & ~st_act_reg;
   wire logic emit_v    = is_code & ~first_act & ~last_act & pend_v_reg;
   wire logic emit_h    = is_code & ~first_act & ~last_act & ~pend_v_reg
                          & pend_h_reg;

   assign ctl_y = first_act ? `VPO_CC_FIRST_ACT :
                  last_act  ? `VPO_CC_LAST_ACT  :
                  emit_v    ? (pend_odd_reg ? `VPO_CC_FS_ODD : `VPO_CC_FS_EVEN) :
                  emit_h    ? (pend_hvb_reg ? `VPO_CC_LS_BLANK : `VPO_CC_LS_ACT) :
                  `VPO_CC_INVALID;

   wire logic [7:0] mark_c  = st_cb_reg ? `VPO_CB_MARK : `VPO_CR_MARK;
   wire logic [7:0] black_y = range ? `VPO_Y_BLACK_FULL : `VPO_Y_BLACK;

   // final pixel bytes of the stage pixel
   wire logic [7:0] out_y = st_act_reg ? lim_y : is_code ? ctl_y : black_y;
   wire logic [7:0] out_c = st_act_reg ? lim_c : is_code ? mark_c :
                            `VPO_C_ZERO;

   // byte lanes by width and slot
   assign lanes_next = stb ? (w8 ? {out_c, 8'h00} : {out_y, out_c}) :
                       (w8 ? {y_hold_reg, 8'h00} : pixel_data_lanes_out);

   // marker clears at a pixel boundary on emission or in mode 1; a new pulse wins
   wire logic clr_v = stb & (emit_v | ~mode2);
   wire logic clr_h = stb & (emit_h | ~mode2);

   always_ff @(posedge full_rate_pixel_clock_in) begin
      if (rst_p) begin
         ph_reg                  <= vpo_pkg::VPO_PH_CHROMA;
         cfg_reg                 <= `VPO_CFG_RESET;
         st_y_reg                <= `VPO_Y_BLACK;
         st_c_reg                <= `VPO_C_ZERO;
         st_act_reg              <= 1'b0;
         st_cb_reg               <= 1'b1;
         prev_act_reg            <= 1'b0;
         pixel_data_lanes_out    <= 16'h0000;
         y_hold_reg              <= 8'h00;
         line_sync_marker_n_out  <= 1'b1;
         field_sync_marker_n_out <= 1'b1;
      end else if (ce_p) begin
         ph_reg               <= ph_next;
         pixel_data_lanes_out <= lanes_next;
         if (stb) begin
            cfg_reg      <= cfg_s;
            st_y_reg     <= src_y_in;
            st_c_reg     <= src_c_in;
            st_act_reg   <= src_active_in;
            st_cb_reg    <= first_act ? 1'b1 : ~st_cb_reg;
            prev_act_reg <= st_act_reg;
            y_hold_reg   <= out_y;
            line_sync_marker_n_out  <= ~(~mode2 & pend_h_reg);
            field_sync_marker_n_out <= ~(~mode2 & pend_v_reg);
         end
      end
   end

   always_ff @(posedge full_rate_pixel_clock_in) begin
      if (rst_p) begin
         pend_h_reg   <= 1'b0;
         pend_hvb_reg <= 1'b0;
         pend_v_reg   <= 1'b0;
         pend_odd_reg <= 1'b0;
      end else if (ce_p) begin
         pend_h_reg <= src_hsync_in | (pend_h_reg & ~clr_h);
         pend_v_reg <= src_vsync_in | (pend_v_reg & ~clr_v);
         if (src_hsync_in) begin
            pend_hvb_reg <= src_vblank_in;
         end
         if (src_vsync_in) begin
            pend_odd_reg <= src_odd_field_in;
         end
      end
   end

   // ---------------- checks ----------------
   default clocking cb_pix @(posedge full_rate_pixel_clock_in);
   endclocking
   default disable iff (rst_p);

   AST_REG_WRITE: assert property (
      @(posedge ref_clk_in) disable iff (rst_in)
      (ce_in && reg_wr_in && ofc_hit) |=>
      output_format_control_reg == ($past(reg_wdata_in) & `VPO_OFC_WMASK))
      else $error("format register write not stored");

   AST_RESET_FORMAT: assert property (
      @(posedge full_rate_pixel_clock_in) disable iff (1'b0)
      rst_p |=> (cfg_reg == `VPO_CFG_RESET) && (pixel_data_lanes_out == 16'h0000))
      else $error("reset format not mode 1, 16-bit");

   AST_PHASE_ALT: assert property (
      ce_p |=> (ph_reg != $past(ph_reg)))
      else $error("pixel slot did not alternate");

   AST_HOLD16: assert property (
      (ce_p && !stb && !w8) |=> $stable(pixel_data_lanes_out))
      else $error("16-bit data changed inside a pixel");

   AST_W8_ORDER: assert property (
      (ce_p && stb && w8) |=> (pixel_data_lanes_out == {$past(out_c), 8'h00})
      ##1 (!$past(ce_p) || pixel_data_lanes_out == {$past(out_y, 2), 8'h00}))
      else $error("8-bit chroma then luma order broken");

   AST_W16_LANES: assert property (
      (ce_p && stb && !w8) |=> (pixel_data_lanes_out == {$past(out_y), $past(out_c)}))
      else $error("16-bit lane placement wrong");

   AST_CODE_MARK: assert property (
      (ce_p && stb && is_code && !w8) |=>
      (pixel_data_lanes_out[7:0] == ($past(st_cb_reg) ? `VPO_CB_MARK : `VPO_CR_MARK)))
      else $error("control code chroma marker wrong");

   AST_CODED_RANGE: assert property (
      (stb && st_act_reg && range && code_en) |->
      (out_y >= `VPO_Y_LO_CODED) && (out_y <= `VPO_Y_HI_CODED) &&
      (out_c >= `VPO_C_LO) && (out_c <= `VPO_C_HI))
      else $error("coded range limit violated");

   AST_STUDIO_RANGE: assert property (
      (stb && st_act_reg && !range) |->
      (out_y >= `VPO_Y_LO_STUDIO) && (out_y <= `VPO_Y_HI_STUDIO))
      else $error("studio luma range violated");

   AST_BLANK_LEVEL: assert property (
      (stb && !st_act_reg && !mode2) |->
      (out_c == `VPO_C_ZERO) && (out_y == (range ? `VPO_Y_BLACK_FULL : `VPO_Y_BLACK)))
      else $error("blank pixel not black with zero colour");

   AST_FIRST_CB: assert property (
      (ce_p && stb && first_act) |=> st_cb_reg ##2 (!ce_p || !st_cb_reg || st_act_reg))
      else $error("first active pixel not flagged Cb");

   AST_FIELD_CODE: assert property (
      (ce_p && stb && emit_v) |=> !pend_v_reg || $past(src_vsync_in))
      else $error("field marker pending after emission");

   AST_W8_LOW_ZERO: assert property (
      (ce_p && w8) |=>
      (pixel_data_lanes_out[7:0] == 8'h00))
      else $error("8-bit low lanes not idle");

   AST_CFG_STABLE: assert property (
      (ce_p && !stb) |=>
      $stable(cfg_reg))
      else $error("format changed inside a pixel");

   AST_TAKE_RATE: assert property (
      src_take_out |=>
      !src_take_out)
      else $error("source taken on two clocks in a row");

   AST_CB_TOGGLE: assert property (
      (ce_p && stb && !first_act) |=>
      (st_cb_reg != $past(st_cb_reg)))
      else $error("chroma flag did not alternate");

   AST_FIRST_CODE: assert property (
      (stb && mode2 && first_act) |->
      (out_y == `VPO_CC_FIRST_ACT))
      else $error("first active code missing");

   AST_LAST_CODE: assert property (
      (stb && mode2 && last_act) |->
      (out_y == `VPO_CC_LAST_ACT))
      else $error("last active code missing");

   AST_LINE_CODE: assert property (
      (stb && emit_h) |->
      (out_y == (pend_hvb_reg ? `VPO_CC_LS_BLANK : `VPO_CC_LS_ACT)))
      else $error("line sync code wrong");

   AST_FIELD_VALUE: assert property (
      (stb && emit_v) |->
      (out_y == (pend_odd_reg ? `VPO_CC_FS_ODD : `VPO_CC_FS_EVEN)))
      else $error("field sync code wrong");

   AST_MARK_HIGH_M2: assert property (
      (ce_p && stb && mode2) |=>
      (line_sync_marker_n_out && field_sync_marker_n_out))
      else $error("marker pin active in coded mode");

   AST_SYNC_MARK_M1: assert property (
      (ce_p && stb && !mode2 && pend_h_reg) |=>
      !line_sync_marker_n_out)
      else $error("line marker pin not driven in mode 1");

   AST_RESERVED: assert property (
      (stb && st_act_reg && !range) |->
      (out_y != 8'h00) && (out_y != 8'hff) && (out_c != 8'h00) && (out_c != 8'hff))
      else $error("reserved value in studio pixel");

   AST_CHROMA_SAT: assert property (
      (stb && st_act_reg) |->
      (out_c >= `VPO_C_LO) && (out_c <= `VPO_C_HI))
      else $error("active chroma outside 2..253");

   AST_NO_FALSE_MARK: assert property (
      (stb && !is_code) |->
      (out_c <= `VPO_C_HI))
      else $error("marker chroma outside a code");

   AST_CODE_LUMA: assert property (
      (stb && is_code) |->
      (out_y <= `VPO_CC_FS_ODD))
      else $error("code luma outside code set");

   COV_W8_MODE2: cover property (ce_p && stb && w8 && mode2 && emit_h);
   COV_W16_MODE1: cover property (ce_p && stb && !w8 && !mode2 && st_act_reg);
   COV_FIELD_ON_CR: cover property (ce_p && stb && emit_v && !st_cb_reg);
   COV_LAST_ACT: cover property (ce_p && stb && is_code && last_act);
   COV_FIRST_CODE: cover property (ce_p && stb && mode2 && first_act);
endmodule

// *** dv/vpo_rx_model.sv ***
// downstream capture model: rebuilds one luma and chroma pair per pixel
// assumes lanes and half-rate clock launched on the full-rate pixel clock
`timescale 1ns/1ns
module vpo_rx_model (
   input  wire logic        clk_in,
   input  wire logic        w8_in,
   input  wire logic        hr_in,
   input  wire logic [15:0] lanes_in
);
   logic [7:0]  c_reg;
   logic [15:0] pix_q[$];
   int          lo_bad;

   initial lo_bad = 0;

   // codes taken whatever their flag position
   always @(posedge clk_in) begin
      if (w8_in && lanes_in[7:0] !== 8'h00) lo_bad++;
      if (hr_in) begin
         c_reg <= lanes_in[15:8];
      end
      if (w8_in ? !hr_in : hr_in) begin
         pix_q.push_back({lanes_in[15:8], w8_in ? c_reg : lanes_in[7:0]});
      end
   end
endmodule

// *** dv/testbench.sv ***
// self-checking bench of the video pixel output port
// assumes vpo_top and vpo_rx_model compiled before it
`timescale 1ns/1ns
module testbench;
   logic        ref_clk_in;
   logic        rst_in;
   logic        ce_in;
   logic        reg_wr_in;
   logic [7:0]  reg_addr_in;
   logic [7:0]  reg_wdata_in;
   logic [7:0]  reg_rdata_out;
   logic        pclk;
   logic [7:0]  src_y_in;
   logic [7:0]  src_c_in;
   logic        src_active_in;
   logic        src_vblank_in;
   logic        src_hsync_in;
   logic        src_vsync_in;
   logic        src_odd_field_in;
   logic        src_take_out;
   logic        hr;
   logic [15:0] lanes;
   logic        w8;
   logic        line_mark_n;
   logic        field_mark_n;
   int          n_line_mark;
   int          n_field_mark;
   int          n_mismatch;
   int          samples_checked;
   int          cyc;

   vpo_top i_vpo_top (
      .ref_clk_in               (ref_clk_in),
      .rst_in                   (rst_in),
      .ce_in                    (ce_in),
      .reg_wr_in                (reg_wr_in),
      .reg_addr_in              (reg_addr_in),
      .reg_wdata_in             (reg_wdata_in),
      .reg_rdata_out            (reg_rdata_out),
      .full_rate_pixel_clock_in (pclk),
      .src_y_in                 (src_y_in),
      .src_c_in                 (src_c_in),
      .src_active_in            (src_active_in),
      .src_vblank_in            (src_vblank_in),
      .src_hsync_in             (src_hsync_in),
      .src_vsync_in             (src_vsync_in),
      .src_odd_field_in         (src_odd_field_in),
      .src_take_out             (src_take_out),
      .half_rate_pixel_clock_out(hr),
      .pixel_data_lanes_out     (lanes),
      .line_sync_marker_n_out   (line_mark_n),
      .field_sync_marker_n_out  (field_mark_n)
   );

   vpo_rx_model i_vpo_rx_model (
      .clk_in  (pclk),
      .w8_in   (w8),
      .hr_in   (hr),
      .lanes_in(lanes)
   );

   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   initial begin
      pclk = 1'b0;
      #3;
      forever #40 pclk = ~pclk;
   end

   task automatic final_report();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         $display("BAD %0t timeout", $time);
         final_report();
      end
   end

   always @(posedge pclk) begin
      if (line_mark_n !== 1'b1) n_line_mark++;
      if (field_mark_n !== 1'b1) n_field_mark++;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   function automatic bit seen(input logic [15:0] e[$]);
      bit ok;
      int n;
      n = i_vpo_rx_model.pix_q.size();
      for (int i = 0; i + e.size() <= n; i++) begin
         ok = 1'b1;
         foreach (e[k]) if (i_vpo_rx_model.pix_q[i + k] !== e[k]) ok = 1'b0;
         if (ok) return 1'b1;
      end
      return 1'b0;
   endfunction

   task automatic want(input logic [15:0] e[$], input string msg);
      chk(16'(seen(e)), 16'h0001, msg);
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge ref_clk_in);
      reg_wr_in = 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk_in);
      reg_addr_in = a;
      @(negedge ref_clk_in);
      d = reg_rdata_out;
   endtask

   task automatic pix(input logic [7:0] y, input logic [7:0] c, input logic a,
                      input logic h, input logic v);
      int n;
      n = 0;
      @(negedge pclk);
      while (src_take_out !== 1'b1 && n < 4) begin
         @(negedge pclk);
         n++;
      end
      src_y_in = y;
      src_c_in = c;
      src_active_in = a;
      src_hsync_in = h;
      src_vsync_in = v;
   endtask

   task automatic line(input int n, input logic [7:0] y, input logic [7:0] c, input logic vb);
      src_vblank_in = vb;
      pix(8'h55, 8'h55, 1'b0, 1'b1, 1'b0);
      repeat (2) pix(8'h55, 8'h55, 1'b0, 1'b0, 1'b0);
      for (int i = 0; i < n; i++) pix(y + 8'(i), c + 8'(i), 1'b1, 1'b0, 1'b0);
      repeat (3) pix(8'h55, 8'h55, 1'b0, 1'b0, 1'b0);
      repeat (6) @(negedge pclk);
   endtask

   task automatic fmt(input logic [7:0] d);
      reg_wr(8'h12, d);
      w8 = d[0];
      repeat (10) @(negedge pclk);
      i_vpo_rx_model.pix_q.delete();
      i_vpo_rx_model.lo_bad = 0;
      n_line_mark = 0;
      n_field_mark = 0;
   endtask

   task automatic t_regs();
      logic [7:0] d;
      reg_rd(8'h12, d);
      chk(16'(d), 16'h0000, "format after reset");
      reg_wr(8'h12, 8'hff);
      reg_rd(8'h12, d);
      chk(16'(d), 16'h000f, "format write");
      reg_wr(8'h13, 8'h5a);
      reg_rd(8'h13, d);
      chk(16'(d), 16'h0000, "unmapped read");
      ce_in = 1'b0;
      reg_wr(8'h12, 8'h00);
      ce_in = 1'b1;
      reg_rd(8'h12, d);
      chk(16'(d), 16'h000f, "write while disabled");
   endtask

   task automatic t_mode1();
      fmt(8'h00);
      line(4, 8'h40, 8'h60, 1'b0);
      want('{16'h1080, 16'h4060, 16'h4161, 16'h4262, 16'h4363, 16'h1080}, "m1 wide");
      chk(16'(n_line_mark), 16'h0002, "wide line marker width");
      chk(16'(n_field_mark), 16'h0000, "wide field marker idle");
      fmt(8'h01);
      line(4, 8'h40, 8'h60, 1'b0);
      want('{16'h1080, 16'h4060, 16'h4161, 16'h4262, 16'h4363, 16'h1080}, "m1 byte");
      chk(16'(i_vpo_rx_model.lo_bad), 16'h0000, "low lanes busy");
      chk(16'(n_line_mark), 16'h0002, "byte line marker width");
      chk(16'(n_field_mark), 16'h0000, "byte field marker idle");
   endtask

   task automatic t_range();
      fmt(8'h04);
      line(1, 8'hff, 8'h00, 1'b0);
      want('{16'h0080, 16'hff02, 16'h0080}, "full range");
      fmt(8'h00);
      line(2, 8'hff, 8'hfe, 1'b0);
      want('{16'h1080, 16'hebfd, 16'h10fd, 16'h1080}, "studio range");
   endtask

   task automatic t_coded();
      logic [15:0] v;
      bit          hit;
      fmt(8'h0f);
      src_odd_field_in = 1'b1;
      pix(8'h55, 8'h55, 1'b0, 1'b0, 1'b1);
      line(0, 8'h00, 8'h00, 1'b1);
      src_odd_field_in = 1'b0;
      pix(8'h55, 8'h55, 1'b0, 1'b0, 1'b1);
      line(4, 8'hff, 8'hfe, 1'b0);
      for (int k = 0; k < 7; k++) begin
         v = {8'(k), 8'hff};
         hit = seen('{v}) | seen('{v ^ 16'h0001});
         chk(16'(hit), 16'h0001, "code absent");
      end
      hit = seen('{16'h02ff, 16'hfdfd}) | seen('{16'h02fe, 16'hfdfd});
      chk(16'(hit), 16'h0001, "first active code");
      want('{16'hfdfd, 16'h10fd, 16'h1002, 16'h1002, 16'h01ff}, "coded run");
      chk(16'(n_line_mark), 16'h0000, "line marker pin in coded mode");
      chk(16'(n_field_mark), 16'h0000, "field marker pin in coded mode");
   endtask

   initial begin
      n_mismatch = 0;
      samples_checked = 0;
      cyc = 0;
      n_line_mark = 0;
      n_field_mark = 0;
      w8 = 1'b0;
      rst_in = 1'b1;
      ce_in = 1'b1;
      reg_wr_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 8'h00;
      src_y_in = 8'h00;
      src_c_in = 8'h00;
      src_active_in = 1'b0;
      src_vblank_in = 1'b0;
      src_hsync_in = 1'b0;
      src_vsync_in = 1'b0;
      src_odd_field_in = 1'b0;
      repeat (12) @(posedge pclk);
      @(negedge ref_clk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge pclk);
      t_regs();
      t_mode1();
      t_range();
      t_coded();
      final_report();
   end
endmodule
